// ---- logic/flash_status_config_protect.sv ----
`timescale 1ns/1ps
module flash_status_config_protect #(
    parameter int         NUM_BLOCKS  = 1024,                 // 64KB blocks
    parameter logic       DEF_BOOT_AW = fscp_pkg::DEF_BOOT_AW, // Boot width default
    parameter logic       DEF_QUAD    = fscp_pkg::DEF_QUAD,    // Quad default
    parameter logic [1:0] DEF_DRV     = fscp_pkg::DEF_DRV      // Strength default
) (
    input  wire logic                          CLK,              // 200 MHz clock
    input  wire logic                          RST,              // Power-up reset
    input  wire logic                          DEV_RESET_N,      // Reset pin, async
    input  wire logic                          CMD_VALID,        // Instruction strobe
    input  wire logic [7:0]                    CMD_OP,           // Instruction code
    input  wire logic [7:0]                    CMD_DATA,         // Write data byte
    input  wire logic [$clog2(NUM_BLOCKS)-1:0] CMD_BLOCK,        // Unlock target block
    input  wire logic                          WRITE_PERMIT,     // Status protect allows
    input  wire logic                          PROT_FROM_BOTTOM, // protect_from_bottom
    input  wire logic [3:0]                    PROT_SIZE_CODE,   // protect_size_code
    input  wire logic                          ERASE_REQ,        // Erase/program ask
    input  wire logic [$clog2(NUM_BLOCKS)-1:0] ERASE_FIRST,      // First target block
    input  wire logic [$clog2(NUM_BLOCKS)-1:0] ERASE_LAST,       // Last target block
    output logic                               ERASE_GRANT,      // Go ahead pulse
    output logic                               ERASE_DENY,       // Ignored pulse
    output logic [7:0]                         READ_DATA,        // Status read byte
    output logic                               READ_VALID,       // Read data pulse
    output logic                               SUSPENDED,        // paused_op_flag
    output logic [2:0]                         SECREG_READ_ONLY, // Security reg locks
    output logic                               QUAD_ENABLE,      // Quad ops allowed
    output logic                               LANE23_DATA,      // Lanes two/three data
    output logic                               PAUSE_PIN_ENABLE, // Pause pin active
    output logic                               ADDR_4BYTE,       // current_addr_width
    output logic [6:0]                         DRIVE_PERCENT     // Read drive strength
);
    localparam int IW = $clog2(NUM_BLOCKS);

    // Whole state of the block in one record
    typedef struct packed {
        logic                  wel;      // Write enable latch
        logic                  paused;   // paused_op_flag
        logic                  invert;   // protect_invert
        logic [2:0]            otp;      // secreg_otp_locks
        logic                  quad;     // four_lane_enable
        logic                  cur_aw;   // current_addr_width
        logic                  boot_aw;  // boot_addr_width
        logic                  scheme;   // protect_scheme_select
        logic [1:0]            drv;      // output_strength
        logic [NUM_BLOCKS-1:0] blk_lock; // Per-block locks
        logic [7:0]            rd;       // Read data
        logic                  rd_vld;   // Read pulse
        logic                  grant;    // Grant pulse
        logic                  deny;     // Deny pulse
        logic                  rs1;      // Reset pin sync, first stage
        logic                  rs2;      // Reset pin sync, second stage
    } fscp_state_t;

    fscp_state_t cur;      // Registered state
    fscp_state_t next_cur; // Next state

    fscp_prot_if #(.NUM_BLOCKS(NUM_BLOCKS)) pif ();

    // Code to drive percent, used by the DRIVE_PERCENT output
    function automatic logic [6:0] fscp_pct(input logic [1:0] code);
        unique case (code)
            2'h0: fscp_pct = fscp_pkg::DRV_PCT_FULL;
            2'h1: fscp_pct = fscp_pkg::DRV_PCT_3Q;
            2'h2: fscp_pct = fscp_pkg::DRV_PCT_HALF;
            2'h3: fscp_pct = fscp_pkg::DRV_PCT_1Q;
        endcase
    endfunction

    fscp_prot_decode #(.NUM_BLOCKS(NUM_BLOCKS)) i_fscp_prot_decode (
        .pif (pif.decoder)
    );

    // Settings and target range handed to the decoder
    assign pif.scheme      = cur.scheme;
    assign pif.invert      = cur.invert;
    assign pif.from_bottom = PROT_FROM_BOTTOM;
    assign pif.size_code   = PROT_SIZE_CODE;
    assign pif.first       = ERASE_FIRST;
    assign pif.last        = ERASE_LAST;
    assign pif.locks       = cur.blk_lock;

    logic dev_rst; // Reset pin held low, after sync
    logic go;      // Instruction accepted this cycle
    logic wr_ok;   // Status write allowed
    assign dev_rst = ~cur.rs2;
    assign go      = CMD_VALID & ~dev_rst;
    assign wr_ok   = cur.wel & WRITE_PERMIT;

    // Next-state logic for the whole block
    always_comb begin
        next_cur = cur;
        next_cur.rs1 = DEV_RESET_N;
        next_cur.rs2 = cur.rs1;
        next_cur.rd_vld = 1'b0;
        next_cur.grant = 1'b0;
        next_cur.deny = 1'b0;
        if (RST) begin
            // Power cycle: volatile state lost, defaults stand in for stored values
            next_cur.wel = 1'b0;
            next_cur.paused = 1'b0;
            next_cur.invert = fscp_pkg::DEF_INVERT;
            next_cur.otp = '0;
            next_cur.quad = DEF_QUAD;
            next_cur.boot_aw = DEF_BOOT_AW;
            next_cur.cur_aw = DEF_BOOT_AW;
            next_cur.scheme = fscp_pkg::DEF_SCHEME;
            next_cur.drv = DEF_DRV;
            next_cur.blk_lock = '1;
            next_cur.rd = '0;
            next_cur.rs1 = 1'b1;
            next_cur.rs2 = 1'b1;
        end else if (dev_rst) begin
            // Device reset keeps stored bits but restarts address mode and locks
            next_cur.wel = 1'b0;
            next_cur.cur_aw = cur.boot_aw;
            next_cur.blk_lock = '1;
        end else if (go) begin
            unique case (CMD_OP)
                fscp_pkg::OP_WR_ENABLE: next_cur.wel = 1'b1;
                fscp_pkg::OP_WR_DISABLE: next_cur.wel = 1'b0;
                fscp_pkg::OP_SUSPEND: next_cur.paused = 1'b1;
                fscp_pkg::OP_RESUME: next_cur.paused = 1'b0;
                fscp_pkg::OP_ADDR4: next_cur.cur_aw = 1'b1;
                fscp_pkg::OP_ADDR3: next_cur.cur_aw = 1'b0;
                fscp_pkg::OP_WR_STAT2: begin
                    // Paused flag and reserved bits in the byte are dropped
                    if (wr_ok) begin
                        next_cur.invert = CMD_DATA[fscp_pkg::INVERT_BIT];
                        next_cur.otp = cur.otp
                            | CMD_DATA[fscp_pkg::OTP_LSB +: fscp_pkg::OTP_W];
                        next_cur.quad = CMD_DATA[fscp_pkg::QUAD_BIT];
                    end
                    next_cur.wel = 1'b0; // Latch is spent either way
                end
                fscp_pkg::OP_WR_STAT3: begin
                    // Current width is status only, so its bit is dropped
                    if (wr_ok) begin
                        next_cur.boot_aw = CMD_DATA[fscp_pkg::BOOT_AW_BIT];
                        next_cur.scheme = CMD_DATA[fscp_pkg::SCHEME_BIT];
                        next_cur.drv = CMD_DATA[fscp_pkg::DRV_LSB +: fscp_pkg::DRV_W];
                    end
                    next_cur.wel = 1'b0; // Latch is spent either way
                end
                fscp_pkg::OP_RD_STAT2: begin
                    next_cur.rd = '0;
                    next_cur.rd[fscp_pkg::PAUSED_BIT] = cur.paused;
                    next_cur.rd[fscp_pkg::INVERT_BIT] = cur.invert;
                    next_cur.rd[fscp_pkg::OTP_LSB +: fscp_pkg::OTP_W] = cur.otp;
                    next_cur.rd[fscp_pkg::QUAD_BIT] = cur.quad;
                    next_cur.rd_vld = 1'b1;
                end
                fscp_pkg::OP_RD_STAT3: begin
                    next_cur.rd = '0;
                    next_cur.rd[fscp_pkg::CUR_AW_BIT] = cur.cur_aw;
                    next_cur.rd[fscp_pkg::BOOT_AW_BIT] = cur.boot_aw;
                    next_cur.rd[fscp_pkg::SCHEME_BIT] = cur.scheme;
                    next_cur.rd[fscp_pkg::DRV_LSB +: fscp_pkg::DRV_W] = cur.drv;
                    next_cur.rd_vld = 1'b1;
                end
                fscp_pkg::OP_BLK_UNLOCK: begin
                    if (cur.wel) begin
                        next_cur.blk_lock[CMD_BLOCK] = 1'b0;
                    end
                    next_cur.wel = 1'b0;
                end
                default: ; // Other instructions belong to other blocks
            endcase
        end
        // Range check runs beside commands; an erase cannot arrive in reset
        if (!RST && !dev_rst && ERASE_REQ) begin
            next_cur.grant = ~pif.hit;
            next_cur.deny = pif.hit;
        end
    end

    // Single register stage for all state
    always_ff @(posedge CLK) begin
        cur <= next_cur;
    end

    // Outputs straight from state
    assign ERASE_GRANT      = cur.grant;
    assign ERASE_DENY       = cur.deny;
    assign READ_DATA        = cur.rd;
    assign READ_VALID       = cur.rd_vld;
    assign SUSPENDED        = cur.paused;
    assign SECREG_READ_ONLY = cur.otp;
    assign QUAD_ENABLE      = cur.quad;
    assign LANE23_DATA      = cur.quad;
    assign PAUSE_PIN_ENABLE = ~cur.quad;
    assign ADDR_4BYTE       = cur.cur_aw;
    assign DRIVE_PERCENT    = fscp_pct(cur.drv);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_suspend_sets: assert property (go && CMD_OP == fscp_pkg::OP_SUSPEND |=> SUSPENDED)
        else $error("suspend did not set paused flag");
    a_resume_clears: assert property (go && CMD_OP == fscp_pkg::OP_RESUME |=> !SUSPENDED)
        else $error("resume did not clear paused flag");
    a_otp_sticky: assert property ((SECREG_READ_ONLY & $past(SECREG_READ_ONLY)) == $past(SECREG_READ_ONLY))
        else $error("security lock bit returned to zero");
    a_otp_single: assert property (go && wr_ok && CMD_OP == fscp_pkg::OP_WR_STAT2 |=>
            SECREG_READ_ONLY == ($past(SECREG_READ_ONLY)
            | $past(CMD_DATA[fscp_pkg::OTP_LSB +: fscp_pkg::OTP_W])))
        else $error("lock write changed other lock bits");
    a_quad_lanes: assert property (go && wr_ok && CMD_OP == fscp_pkg::OP_WR_STAT2 |=>
            QUAD_ENABLE == $past(CMD_DATA[fscp_pkg::QUAD_BIT])
            && LANE23_DATA == $past(CMD_DATA[fscp_pkg::QUAD_BIT])
            && PAUSE_PIN_ENABLE == !$past(CMD_DATA[fscp_pkg::QUAD_BIT]))
        else $error("quad enable and pause pin disagree");
    a_width_ro: assert property (go && CMD_OP == fscp_pkg::OP_WR_STAT3 |=> $stable(ADDR_4BYTE))
        else $error("status write changed current width");
    a_reset_width: assert property (dev_rst ##1 dev_rst |-> ADDR_4BYTE == cur.boot_aw)
        else $error("device reset did not load boot width");
    a_reset_locks: assert property (dev_rst |=> &cur.blk_lock)
        else $error("device reset left a block unlocked");
    a_empty_grant: assert property (ERASE_REQ && !dev_rst && !cur.scheme && !cur.invert
            && PROT_SIZE_CODE == fscp_pkg::SIZE_NONE |=> ERASE_GRANT && !ERASE_DENY)
        else $error("unprotected array refused an erase");
    a_full_deny: assert property (ERASE_REQ && !dev_rst && !cur.scheme && !cur.invert
            && PROT_SIZE_CODE > fscp_pkg::SIZE_LAST |=> ERASE_DENY && !ERASE_GRANT)
        else $error("fully protected array granted an erase");
    a_drive_map: assert property (cur.drv == 2'h1 |->
            DRIVE_PERCENT == fscp_pkg::DRV_PCT_3Q)
        else $error("drive code one not seventy five percent");

    c_suspend_resume: cover property (SUSPENDED ##[1:20] !SUSPENDED);
    c_erase_denied: cover property (ERASE_DENY);
    c_quad_on: cover property ($rose(QUAD_ENABLE));
    c_four_byte: cover property ($rose(ADDR_4BYTE));
endmodule

// ---- logic/fscp_prot_decode.sv ----
`timescale 1ns/1ps
// Decides whether a block range touches any protected block
module fscp_prot_decode #(
    parameter int NUM_BLOCKS = 1024 // 64KB blocks in the array
) (
    fscp_prot_if.decoder pif // Settings in, hit out
);
    localparam int IW = $clog2(NUM_BLOCKS);
    localparam int CW = IW + 1;
    localparam logic [CW-1:0] ALL_BLK = CW'(NUM_BLOCKS);

    // The largest partial code covers 512 blocks, so the array must hold them
    if (NUM_BLOCKS < 512 || (1 << IW) != NUM_BLOCKS) begin : g_bad
        $error("fscp_prot_decode: NUM_BLOCKS must be a power of two, at least 512");
    end

    logic [NUM_BLOCKS-1:0] in_range; // Blocks inside the target range

    // One compare pair per block for the lock-bit scheme
    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_rng
        assign in_range[i] = (IW'(i) >= pif.first) && (IW'(i) <= pif.last);
    end

    // Size-code scheme: count, side, then range overlap
    always_comb begin
        logic [CW-1:0] cnt;
        logic          bottom;
        logic [CW-1:0] lo;
        logic [CW-1:0] hi;
        logic          hit_size;
        cnt = '0;
        bottom = pif.from_bottom;
        lo = '0;
        hi = '0;
        hit_size = 1'b0;
        if (pif.size_code == fscp_pkg::SIZE_NONE) begin
            cnt = '0;
        end else if (pif.size_code <= fscp_pkg::SIZE_LAST) begin
            cnt = CW'(1) << (pif.size_code - 4'h1);
        end else begin
            cnt = ALL_BLK;
        end
        // Inversion protects the complement, which lies on the other side
        if (pif.invert) begin
            cnt = ALL_BLK - cnt;
            bottom = ~pif.from_bottom;
        end
        if (bottom) begin
            lo = '0;
            hi = cnt - CW'(1);
        end else begin
            lo = ALL_BLK - cnt;
            hi = ALL_BLK - CW'(1);
        end
        // Any overlap at all protects the whole command
        hit_size = (cnt != '0) && ({1'b0, pif.first} <= hi) && ({1'b0, pif.last} >= lo);
        pif.hit = pif.scheme ? |(in_range & pif.locks) : hit_size;
    end
endmodule

// ---- shared/fscp_pkg.sv ----
package fscp_pkg;
    // Instruction codes seen on the command port
    localparam logic [7:0] OP_WR_ENABLE  = 8'h06; // Sets the write latch
    localparam logic [7:0] OP_WR_DISABLE = 8'h04; // Clears the write latch
    localparam logic [7:0] OP_WR_STAT2   = 8'h31; // Write status/config two
    localparam logic [7:0] OP_WR_STAT3   = 8'h11; // Write status/config three
    localparam logic [7:0] OP_RD_STAT2   = 8'h35; // Read status/config two
    localparam logic [7:0] OP_RD_STAT3   = 8'h15; // Read status/config three
    localparam logic [7:0] OP_SUSPEND    = 8'h75; // Erase/program suspend
    localparam logic [7:0] OP_RESUME     = 8'h7A; // Erase/program resume
    localparam logic [7:0] OP_ADDR4      = 8'hB7; // Enter four-byte addressing
    localparam logic [7:0] OP_ADDR3      = 8'hE9; // Leave four-byte addressing
    localparam logic [7:0] OP_BLK_UNLOCK = 8'h39; // Clear one block lock bit

    // Field positions in status/config two
    localparam int PAUSED_BIT = 7; // paused_op_flag
    localparam int INVERT_BIT = 6; // protect_invert
    localparam int OTP_LSB    = 3; // secreg_otp_locks, three bits upward
    localparam int QUAD_BIT   = 1; // four_lane_enable
    // Field positions in status/config three
    localparam int CUR_AW_BIT  = 0; // current_addr_width
    localparam int BOOT_AW_BIT = 1; // boot_addr_width
    localparam int SCHEME_BIT  = 2; // protect_scheme_select
    localparam int DRV_LSB     = 5; // output_strength, two bits upward

    localparam int OTP_W  = 3; // Number of security register locks
    localparam int DRV_W  = 2; // Output strength field width
    localparam int SIZE_W = 4; // protect_size_code width
    localparam logic [SIZE_W-1:0] SIZE_NONE = 4'h0; // Protects nothing
    localparam logic [SIZE_W-1:0] SIZE_LAST = 4'hA; // Largest partial code

    // Drive strength in percent, per output_strength code
    localparam logic [6:0] DRV_PCT_FULL  = 7'h64; // 100 %
    localparam logic [6:0] DRV_PCT_3Q    = 7'h4B; // 75 %
    localparam logic [6:0] DRV_PCT_HALF  = 7'h32; // 50 %
    localparam logic [6:0] DRV_PCT_1Q    = 7'h19; // 25 %

    // Factory defaults of the writable fields
    localparam logic             DEF_BOOT_AW = 1'b0; // Three-byte start
    localparam logic             DEF_QUAD    = 1'b0; // Pause pin active
    localparam logic             DEF_SCHEME  = 1'b0; // Size-code scheme
    localparam logic             DEF_INVERT  = 1'b0; // No inversion
    localparam logic [DRV_W-1:0] DEF_DRV     = 2'h0; // Full strength
endpackage

// ---- shared/fscp_prot_if.sv ----
`timescale 1ns/1ps
// Carries the protection settings and one erase/program range to the decoder
interface fscp_prot_if #(parameter int NUM_BLOCKS = 1024);
    localparam int IW = $clog2(NUM_BLOCKS);
    logic                  scheme;      // protect_scheme_select
    logic                  invert;      // protect_invert
    logic                  from_bottom; // protect_from_bottom
    logic [3:0]            size_code;   // protect_size_code
    logic [IW-1:0]         first;       // First 64KB block of the target
    logic [IW-1:0]         last;        // Last 64KB block of the target
    logic [NUM_BLOCKS-1:0] locks;       // Per-block lock bits
    logic                  hit;         // Target touches protected area

    modport owner (output scheme, invert, from_bottom, size_code, first, last, locks,
                   input hit);
    modport decoder (input scheme, invert, from_bottom, size_code, first, last, locks,
                     output hit);
endinterface

// ---- tb/flash_status_config_protect_test.sv ----
`timescale 1ns/1ps
// Walks the status/config block through its instruction and range check ports
module flash_status_config_protect_test;
    logic       clk, rst, dev_reset_n, write_permit, prot_from_bottom; // Driven levels
    logic [3:0] prot_size_code;                                       // Size code
    logic       cmd_valid, erase_req, erase_grant, erase_deny, read_valid; // Strobes
    logic [7:0] cmd_op, cmd_data, read_data;                          // Bytes
    logic [9:0] cmd_block, erase_first, erase_last;                   // Block indices
    logic       suspended, quad_enable, lane23_data, pause_pin_enable, addr_4byte; // Levels
    logic [2:0] secreg_read_only;                                     // Security locks
    logic [6:0] drive_percent;                                        // Drive strength
    int         errors;                                               // Mismatches
    int         checked;                                              // Comparisons

    flash_status_config_protect i_flash_status_config_protect (
        .CLK(clk), .RST(rst), .DEV_RESET_N(dev_reset_n), .CMD_VALID(cmd_valid),
        .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_BLOCK(cmd_block),
        .WRITE_PERMIT(write_permit), .PROT_FROM_BOTTOM(prot_from_bottom),
        .PROT_SIZE_CODE(prot_size_code), .ERASE_REQ(erase_req), .ERASE_FIRST(erase_first),
        .ERASE_LAST(erase_last), .ERASE_GRANT(erase_grant), .ERASE_DENY(erase_deny),
        .READ_DATA(read_data), .READ_VALID(read_valid), .SUSPENDED(suspended),
        .SECREG_READ_ONLY(secreg_read_only), .QUAD_ENABLE(quad_enable),
        .LANE23_DATA(lane23_data), .PAUSE_PIN_ENABLE(pause_pin_enable),
        .ADDR_4BYTE(addr_4byte), .DRIVE_PERCENT(drive_percent)
    );

    fscp_host_model i_fscp_host_model (
        .CLK(clk), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_DATA(cmd_data),
        .CMD_BLOCK(cmd_block), .ERASE_REQ(erase_req), .ERASE_FIRST(erase_first),
        .ERASE_LAST(erase_last), .ERASE_GRANT(erase_grant), .ERASE_DENY(erase_deny),
        .READ_DATA(read_data), .READ_VALID(read_valid)
    );

    // Counts every comparison and reports a mismatch at once
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Status read; the valid pulse must come with the byte
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        logic [8:0] r;
        i_fscp_host_model.read(op, r);
        check({7'h00, r}, {8'h01, exp});
    endtask

    // Instruction without data
    task automatic cmd(input logic [7:0] op, input logic [9:0] blk);
        i_fscp_host_model.cmd(op, 8'h00, blk);
    endtask

    // Latched status write
    task automatic wr(input logic [7:0] op, input logic [7:0] dat);
        i_fscp_host_model.wr(op, dat);
    endtask

    // Range check: exactly one of grant or deny, deny when protection is hit
    task automatic er(input int f, input int l, input logic hit);
        logic [1:0] r;
        i_fscp_host_model.erase(f[9:0], l[9:0], r);
        check({14'h0000, r}, {14'h0000, ~hit, hit});
    endtask

    // Protected set is a prefix or suffix of n blocks, flipped by the invert bit
    function automatic logic prot(input int k, input logic bot, input logic inv, input int n);
        return inv ^ (bot ? (k < n) : (k >= 1024 - n));
    endfunction

    // Prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // The whole run is about a thousand cycles; this span is far beyond it
    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        int n;
        int k;
        int pts[6];
        logic [6:0] pct[4];
        {errors, checked} = {32'h0, 32'h0};
        {rst, dev_reset_n, write_permit, prot_from_bottom, prot_size_code} = 8'hE0;
        pct = '{7'h64, 7'h4B, 7'h32, 7'h19};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        rd(fscp_pkg::OP_RD_STAT2, 8'h00);
        rd(fscp_pkg::OP_RD_STAT3, 8'h00);
        check({9'h000, drive_percent}, {9'h000, pct[0]});
        // Refused writes: first without the latch, then without permission
        i_fscp_host_model.cmd(fscp_pkg::OP_WR_STAT2, 8'h08, 10'h000);
        write_permit = 1'b0;
        wr(fscp_pkg::OP_WR_STAT2, 8'h08);
        write_permit = 1'b1;
        rd(fscp_pkg::OP_RD_STAT2, 8'h00);
        // Locks set one by one; read-only and reserved bits poked
        wr(fscp_pkg::OP_WR_STAT2, 8'h08);
        check({13'h0000, secreg_read_only}, 16'h0001);
        wr(fscp_pkg::OP_WR_STAT2, 8'h10);
        wr(fscp_pkg::OP_WR_STAT2, 8'h87);
        rd(fscp_pkg::OP_RD_STAT2, 8'h1A);
        check({13'h0000, quad_enable, lane23_data, pause_pin_enable}, 16'h0006);
        cmd(fscp_pkg::OP_SUSPEND, 10'h000);
        rd(fscp_pkg::OP_RD_STAT2, 8'h9A);
        cmd(fscp_pkg::OP_RESUME, 10'h000);
        check({15'h0000, suspended}, 16'h0000);
        wr(fscp_pkg::OP_WR_STAT2, 8'h00);
        rd(fscp_pkg::OP_RD_STAT2, 8'h18);
        check({13'h0000, quad_enable, lane23_data, pause_pin_enable}, 16'h0001);
        // Every size code both ways, plain and inverted, probed at the region edges
        for (int inv = 0; inv < 2; inv++) begin
            wr(fscp_pkg::OP_WR_STAT2, (inv != 0) ? 8'h40 : 8'h00);
            for (int b = 0; b < 32; b++) begin
                prot_from_bottom = b[4];
                prot_size_code = b[3:0];
                n = (b[3:0] == 0) ? 0 : (b[3:0] <= 10) ? (1 << (b[3:0] - 1)) : 1024;
                pts = '{0, n - 1, n, 1023 - n, 1024 - n, 1023};
                foreach (pts[i]) begin
                    k = (pts[i] < 0) ? 0 : (pts[i] > 1023) ? 1023 : pts[i];
                    er(k, k, prot(k, b[4], inv[0], n));
                end
                er(0, 1023, prot(0, b[4], inv[0], n) | prot(1023, b[4], inv[0], n));
            end
        end
        // Each strength code, with scheme and boot width set and bit 0 poked
        for (int d = 0; d < 4; d++) begin
            wr(fscp_pkg::OP_WR_STAT3, {1'b0, d[1:0], 5'h07});
            check({9'h000, drive_percent}, {9'h000, pct[d]});
        end
        rd(fscp_pkg::OP_RD_STAT3, 8'h66);
        // Lock scheme: size code says all, yet only the lock bits count
        er(5, 5, 1'b1);
        cmd(fscp_pkg::OP_BLK_UNLOCK, 10'h005);
        er(5, 5, 1'b1);
        cmd(fscp_pkg::OP_WR_ENABLE, 10'h000);
        cmd(fscp_pkg::OP_BLK_UNLOCK, 10'h005);
        er(5, 5, 1'b0);
        // Latch withdrawn before the unlock, so block six stays locked
        cmd(fscp_pkg::OP_WR_ENABLE, 10'h000);
        cmd(fscp_pkg::OP_WR_DISABLE, 10'h000);
        cmd(fscp_pkg::OP_BLK_UNLOCK, 10'h006);
        er(6, 6, 1'b1);
        er(4, 6, 1'b1);
        cmd(fscp_pkg::OP_ADDR4, 10'h000);
        rd(fscp_pkg::OP_RD_STAT3, 8'h67);
        cmd(fscp_pkg::OP_ADDR3, 10'h000);
        check({15'h0000, addr_4byte}, 16'h0000);
        // Device reset pin: boot width reloads the mode and the locks return
        dev_reset_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 dev_reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({15'h0000, addr_4byte}, 16'h0001);
        er(5, 5, 1'b1);
        // Power cycle in mid-run: the paused flag must not survive it
        cmd(fscp_pkg::OP_SUSPEND, 10'h000);
        check({15'h0000, suspended}, 16'h0001);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check({15'h0000, suspended}, 16'h0000);
        give_verdict();
    end
endmodule

// ---- tb/fscp_host_model.sv ----
`timescale 1ns/1ps
// Host side of the instruction link: one instruction or one range check at a time
module fscp_host_model (
    input  wire logic       CLK,         // Device clock
    output logic            CMD_VALID,   // Instruction strobe
    output logic [7:0]      CMD_OP,      // Instruction code
    output logic [7:0]      CMD_DATA,    // Status write byte
    output logic [9:0]      CMD_BLOCK,   // Unlock target block
    output logic            ERASE_REQ,   // Range check request
    output logic [9:0]      ERASE_FIRST, // First target block
    output logic [9:0]      ERASE_LAST,  // Last target block
    input  wire logic       ERASE_GRANT, // Go ahead pulse
    input  wire logic       ERASE_DENY,  // Ignored pulse
    input  wire logic [7:0] READ_DATA,   // Status byte
    input  wire logic       READ_VALID   // Read data pulse
);
    // Idle from time zero
    initial begin
        {CMD_VALID, CMD_OP, CMD_DATA, CMD_BLOCK} = 27'h0000000;
        {ERASE_REQ, ERASE_FIRST, ERASE_LAST} = 21'h000000;
    end

    // One strobe cycle; idle lines then carry the inverse so stale values never pass
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic [9:0] blk);
        @(posedge CLK) #1;
        {CMD_VALID, CMD_OP, CMD_DATA, CMD_BLOCK} = {1'b1, op, dat, blk};
        @(posedge CLK) #1;
        {CMD_VALID, CMD_OP, CMD_DATA, CMD_BLOCK} = {1'b0, ~op, ~dat, ~blk};
    endtask

    // Status write always preceded by the write latch instruction
    task automatic wr(input logic [7:0] op, input logic [7:0] dat);
        cmd(fscp_pkg::OP_WR_ENABLE, 8'h00, 10'h000);
        cmd(op, dat, 10'h000);
    endtask

    // Read pulse stands one cycle, so it is taken right after the taking edge
    task automatic read(input logic [7:0] op, output logic [8:0] r);
        cmd(op, 8'h00, 10'h000);
        r = {READ_VALID, READ_DATA};
    endtask

    // Range check; the answer stands only in the cycle after the request
    task automatic erase(input logic [9:0] f, input logic [9:0] l, output logic [1:0] r);
        @(posedge CLK) #1;
        {ERASE_REQ, ERASE_FIRST, ERASE_LAST} = {1'b1, f, l};
        @(posedge CLK) #1;
        {ERASE_REQ, ERASE_FIRST, ERASE_LAST} = {1'b0, ~f, ~l};
        r = {ERASE_GRANT, ERASE_DENY};
    endtask
endmodule
